//--- rscr_pkg.sv
// package of constants for the radio serial configuration register bank
// Function
// [RQ1] programming uses whole 16-bit words, each one register write
// [RQ2] word holds 14 data bits on top, 2-bit select code lowest
// [RQ3] select code 00 is synthesizer config, 01 is channel divide ratio
// [RQ4] exactly three writable registers: config, channel, test
// [RQ5] no read-back path over the serial bus
// [RQ6] host writes zero to all reserved data bits
// [RQ7] config bit 9 disables signal-strength clipping
// [RQ8] config bit 8 arms low-supply lockout of amplifier enable, cleared by receive-on
// [RQ9] config bit 6 makes transmit RF output follow amplifier enable
// [RQ10] config bit 5 sets power pin: 0 pulled low, 1 high impedance; code also leaves the pin high impedance while bit 2 is set
// [RQ11] config bit 4 selects unmodulated continuous carrier
// [RQ12] config bit 2 selects analog-out pin function
// [RQ13] config bit 1 selects 12.288MHz reference, else 6.144MHz
// [RQ14] config bit 0 sets charge pump polarity
// [RQ15] channel bits 11..0 hold 12-bit divide ratio
// [RQ16] test register: digital selector bits 5..3, analog selector bits 2..0
// [RQ17] every register bit clears to zero at power-up, valid immediately
// [RQ18] power-up is the release of reset; zero defaults apply from there
// [RQ19] while enable low, data shifts in msb first on serial clock rise
// [RQ20] on enable rise, decode select code and load 14 data bits
// [RQ21] while enable high, data and clock pins are ignored
// [RQ22] host clocks at least 16 bits before raising enable
// [RQ23] select code 10 is test register; code 11 changes nothing
// [RQ24] fields drive outputs from stored value, changing only on a full load
package rscr_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 14;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_CONFIG = 2'h0;
  localparam logic [1:0] SEL_CHANNEL = 2'h1;
  localparam logic [1:0] SEL_TEST = 2'h2;
  localparam logic [13:0] REG_RESET = 14'h0000;
  localparam int CFG_CLIP_DIS = 9;
  localparam int CFG_LOCKOUT = 8;
  localparam int CFG_TX_TIMING = 6;
  localparam int CFG_PWR_PIN = 5;
  localparam int CFG_CW = 4;
  localparam int CFG_ANALOG_OUT_FUNCTION_FN = 2;
  localparam int CFG_REF_SEL = 1;
  localparam int CFG_PUMP_POL = 0;
  localparam int CHQ_W = 12;
  localparam int TST_DIG_LSB = 3;
  localparam int TST_ANA_LSB = 0;
  localparam int TST_W = 3;
endpackage

//--- rscr_sync.sv
// two-flop synchroniser for one pin
`timescale 1ns/1ps
module rscr_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pin in, synchronised out
  input wire logic pin,
  output logic sync
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  always_comb begin
    meta_d = pin;
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= meta_q;
    end
  end
  assign sync = sync_q;
endmodule

//--- rscr_shift.sv
// serial word shifter with enable-rise load strobe
`timescale 1ns/1ps
module rscr_shift #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // synchronised serial pins
  input wire logic en_s,
  input wire logic sclk_s,
  input wire logic sdata_s,
  // word out
  output logic [WIDTH-1:0] word,
  output logic load
);
  logic [WIDTH-1:0] sr_q;
  logic [WIDTH-1:0] sr_d;
  logic sclk_q;
  logic en_q;
  logic load_d;
  logic load_q;
  if (WIDTH < 3) begin : g_width_check
    $error("shift width too small");
  end
  always_comb begin
    sr_d = sr_q;
    if (!en_s && sclk_s && !sclk_q) begin
      sr_d = {sr_q[WIDTH-2:0], sdata_s}; // RQ19
    end
    load_d = en_s && !en_q; // RQ20 RQ21
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sr_q <= '0;
      sclk_q <= 1'b0;
      en_q <= 1'b1;
      load_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      sclk_q <= sclk_s;
      en_q <= en_s;
      load_q <= load_d;
    end
  end
  assign word = sr_q;
  assign load = load_q;
endmodule

//--- rscr_top.sv
// radio serial configuration register bank, top level
`timescale 1ns/1ps
module rscr_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // three-wire programming bus
  input wire logic SER_EN,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  // live radio status
  input wire logic RECEIVE_ON,
  input wire logic ANALOG_SUPPLY_LOW,
  input wire logic AMP_ENABLE_REQ,
  // configuration fields
  output logic STRENGTH_CLIP_DISABLE,
  output logic LOW_SUPPLY_LOCKOUT_ARM,
  output logic TX_RF_OUTPUT_TIMING,
  output logic TX_POWER_PIN_STATE,
  output logic CONTINUOUS_CARRIER_SELECT,
  output logic ANALOG_OUT_FUNCTION,
  output logic REFERENCE_FREQ_SELECT,
  output logic PUMP_POLARITY,
  output logic [11:0] CHANNEL_DIVIDE_RATIO_FIELD,
  output logic [2:0] DIGITAL_TEST_SELECT,
  output logic [2:0] ANALOG_TEST_SELECT,
  // derived controls
  output logic AMPLIFIER_ENABLE_OUT,
  output logic TX_RF_ENABLE,
  output logic POWER_PIN_OE
);
  logic en_s;
  logic sclk_s;
  logic sdata_s;
  logic rx_s;
  logic low_s;
  logic amp_s;
  logic [15:0] word;
  logic load;
  logic [13:0] cfg_q;
  logic [13:0] cfg_d;
  logic [13:0] chn_q;
  logic [13:0] chn_d;
  logic [13:0] tst_q;
  logic [13:0] tst_d;
  logic lock_q;
  logic lock_d;
  logic amp_q;
  logic amp_d;
  logic rf_q;
  logic rf_d;
  logic oe_q;
  logic oe_d;
  logic [13:0] data_f;
  logic [1:0] sel_f;

  logic [5:0] pins;
  logic [5:0] pins_s;
  assign pins = {SER_EN, SER_CLK, SER_DATA, RECEIVE_ON, ANALOG_SUPPLY_LOW, AMP_ENABLE_REQ};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_sync
      // enable pin idles high, so its synchroniser resets high
      rscr_sync #(.RST_VAL(gi == 5)) u_sync (
        .clk(CLOCK),
        .rst_b(RST_B),
        .pin(pins[gi]),
        .sync(pins_s[gi])
      );
    end
  endgenerate
  assign {en_s, sclk_s, sdata_s, rx_s, low_s, amp_s} = pins_s;

  rscr_shift #(.WIDTH(rscr_pkg::WORD_W)) u_shift (
    .clk(CLOCK),
    .rst_b(RST_B),
    .en_s(en_s),
    .sclk_s(sclk_s),
    .sdata_s(sdata_s),
    .word(word),
    .load(load)
  );

  // split word: data on top, select code lowest
  assign data_f = word[rscr_pkg::WORD_W-1:rscr_pkg::SEL_W]; // RQ1 RQ2
  assign sel_f = word[rscr_pkg::SEL_W-1:0]; // RQ2

  // register load, no read path exists
  always_comb begin
    cfg_d = cfg_q;
    chn_d = chn_q;
    tst_d = tst_q;
    if (load) begin
      unique case (sel_f)
        rscr_pkg::SEL_CONFIG: cfg_d = data_f; // RQ3 RQ4 RQ20
        rscr_pkg::SEL_CHANNEL: chn_d = data_f; // RQ3 RQ20
        rscr_pkg::SEL_TEST: tst_d = data_f; // RQ23
        default: begin
          cfg_d = cfg_q; // RQ23
        end
      endcase
    end
  end
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_q <= rscr_pkg::REG_RESET; // RQ17 RQ18
      chn_q <= rscr_pkg::REG_RESET;
      tst_q <= rscr_pkg::REG_RESET;
    end else begin
      cfg_q <= cfg_d; // RQ24 RQ5
      chn_q <= chn_d;
      tst_q <= tst_d;
    end
  end

  // lockout latch and derived controls
  always_comb begin
    lock_d = lock_q;
    if (rx_s) begin
      lock_d = 1'b0; // RQ8
    end else if (cfg_q[rscr_pkg::CFG_LOCKOUT] && low_s) begin
      lock_d = 1'b1; // RQ8
    end
    amp_d = amp_s && !(lock_d && cfg_q[rscr_pkg::CFG_LOCKOUT]); // RQ8
    rf_d = cfg_q[rscr_pkg::CFG_TX_TIMING] ? amp_d : 1'b1; // RQ9
    oe_d = !cfg_q[rscr_pkg::CFG_ANALOG_OUT_FUNCTION_FN] && !cfg_q[rscr_pkg::CFG_PWR_PIN]; // RQ10 RQ12
  end
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lock_q <= 1'b0;
      amp_q <= 1'b0;
      rf_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      amp_q <= amp_d;
      rf_q <= rf_d;
      oe_q <= oe_d;
    end
  end

  // field outputs straight from stored registers
  assign STRENGTH_CLIP_DISABLE = cfg_q[rscr_pkg::CFG_CLIP_DIS]; // RQ7
  assign LOW_SUPPLY_LOCKOUT_ARM = cfg_q[rscr_pkg::CFG_LOCKOUT];
  assign TX_RF_OUTPUT_TIMING = cfg_q[rscr_pkg::CFG_TX_TIMING];
  assign TX_POWER_PIN_STATE = cfg_q[rscr_pkg::CFG_PWR_PIN]; // RQ10
  assign CONTINUOUS_CARRIER_SELECT = cfg_q[rscr_pkg::CFG_CW]; // RQ11
  assign ANALOG_OUT_FUNCTION = cfg_q[rscr_pkg::CFG_ANALOG_OUT_FUNCTION_FN]; // RQ12
  assign REFERENCE_FREQ_SELECT = cfg_q[rscr_pkg::CFG_REF_SEL]; // RQ13
  assign PUMP_POLARITY = cfg_q[rscr_pkg::CFG_PUMP_POL]; // RQ14
  assign CHANNEL_DIVIDE_RATIO_FIELD = chn_q[rscr_pkg::CHQ_W-1:0]; // RQ15
  assign DIGITAL_TEST_SELECT = tst_q[rscr_pkg::TST_DIG_LSB +: rscr_pkg::TST_W]; // RQ16
  assign ANALOG_TEST_SELECT = tst_q[rscr_pkg::TST_ANA_LSB +: rscr_pkg::TST_W]; // RQ16
  assign AMPLIFIER_ENABLE_OUT = amp_q;
  assign TX_RF_ENABLE = rf_q;
  assign POWER_PIN_OE = oe_q;
endmodule

//--- rscr_props.sv
// checker of the radio serial configuration register bank
`timescale 1ns/1ps
module rscr_props (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_B,
  // bus enable and live radio status
  input wire logic SER_EN,
  input wire logic RECEIVE_ON,
  input wire logic ANALOG_SUPPLY_LOW,
  input wire logic AMP_ENABLE_REQ,
  // configuration fields
  input wire logic STRENGTH_CLIP_DISABLE,
  input wire logic LOW_SUPPLY_LOCKOUT_ARM,
  input wire logic TX_RF_OUTPUT_TIMING,
  input wire logic TX_POWER_PIN_STATE,
  input wire logic CONTINUOUS_CARRIER_SELECT,
  input wire logic ANALOG_OUT_FUNCTION,
  input wire logic REFERENCE_FREQ_SELECT,
  input wire logic PUMP_POLARITY,
  input wire logic [11:0] CHANNEL_DIVIDE_RATIO_FIELD,
  input wire logic [2:0] DIGITAL_TEST_SELECT,
  input wire logic [2:0] ANALOG_TEST_SELECT,
  // derived controls
  input wire logic AMPLIFIER_ENABLE_OUT,
  input wire logic TX_RF_ENABLE,
  input wire logic POWER_PIN_OE
);
  logic [25:0] fields;
  logic en_q;
  logic [3:0] gap_q;
  assign fields = {STRENGTH_CLIP_DISABLE, LOW_SUPPLY_LOCKOUT_ARM, TX_RF_OUTPUT_TIMING,
    TX_POWER_PIN_STATE, CONTINUOUS_CARRIER_SELECT, ANALOG_OUT_FUNCTION, REFERENCE_FREQ_SELECT,
    PUMP_POLARITY, CHANNEL_DIVIDE_RATIO_FIELD, DIGITAL_TEST_SELECT, ANALOG_TEST_SELECT};
  // cycles since the enable pin last rose
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      en_q <= 1'b1;
      gap_q <= 4'hf;
    end else begin
      en_q <= SER_EN;
      gap_q <= (SER_EN && !en_q) ? 4'h0 : ((gap_q == 4'hf) ? gap_q : gap_q + 4'h1);
    end
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  sequence lock_s;
    (LOW_SUPPLY_LOCKOUT_ARM && ANALOG_SUPPLY_LOW && !RECEIVE_ON)[*6];
  endsequence
  sequence clear_s;
    (RECEIVE_ON && AMP_ENABLE_REQ)[*6];
  endsequence
  AST_RESET_ZERO: assert property ($rose(RST_B) |-> fields == 26'h0)
    else $error("fields not zero after reset");
  AST_LOAD_AFTER_EN: assert property ($changed(fields) |-> gap_q inside {[2:7]})
    else $error("field changed without an enable rise");
  AST_TX_ALWAYS_ON: assert property (!TX_RF_OUTPUT_TIMING [*2] |-> TX_RF_ENABLE)
    else $error("tx rf not on with timing bit clear");
  AST_TX_FOLLOWS: assert property (TX_RF_OUTPUT_TIMING [*2] |->
    TX_RF_ENABLE == AMPLIFIER_ENABLE_OUT)
    else $error("tx rf not following amplifier enable");
  AST_PIN_OE: assert property ($past(RST_B) |->
    POWER_PIN_OE == $past(!ANALOG_OUT_FUNCTION && !TX_POWER_PIN_STATE))
    else $error("power pin enable wrong");
  AST_LOCKOUT: assert property (lock_s |-> !AMPLIFIER_ENABLE_OUT)
    else $error("amplifier enable not locked out");
  AST_CLEAR_WINS: assert property (clear_s |-> AMPLIFIER_ENABLE_OUT)
    else $error("receive-on did not clear lockout");
  AST_UNARMED: assert property ((!LOW_SUPPLY_LOCKOUT_ARM && AMP_ENABLE_REQ)[*6] |->
    AMPLIFIER_ENABLE_OUT)
    else $error("amplifier enable disturbed while unarmed");
endmodule
bind rscr_top rscr_props i_props (.*);

//--- rscr_host.sv
// host model driving the three-wire programming bus
`timescale 1ns/1ps
module rscr_host (
  // bench clock for pacing
  input wire logic clk,
  // bus pins
  output logic ser_en,
  output logic ser_clk,
  output logic ser_data
);
  initial begin
    ser_en = 1'b1;
    ser_clk = 1'b0;
    ser_data = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  // one whole word, msb first, data moved while the clock is low
  task automatic send(input logic [15:0] w);
    @(negedge clk) ser_en <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_data <= w[i];
      half();
      ser_clk <= 1'b1;
      half();
      ser_clk <= 1'b0;
    end
    half();
    ser_en <= 1'b1;
    ser_data <= ~w[0];
  endtask
  // bus activity while enable is high
  task automatic noise();
    repeat (4) begin
      half();
      ser_clk <= 1'b1;
      ser_data <= ~ser_data;
      half();
      ser_clk <= 1'b0;
    end
  endtask
endmodule

//--- rscr_top_bench.sv
// self-checking bench of the radio serial configuration register bank
`timescale 1ns/1ps
module rscr_top_bench;
  logic clk, rst_b, rx_on, sup_low, amp_req, en, sck, sda;
  logic clip, lock, tm, pps, cw, aof, ref_sel, pol, amp, txrf, oe;
  logic [11:0] channel_divide_ratio_field;
  logic [2:0] dts, ats;
  int error_cnt = 0;
  int checks_done = 0;
  rscr_host i_host (.clk(clk), .ser_en(en), .ser_clk(sck), .ser_data(sda));
  rscr_top i_dut (.CLOCK(clk), .RST_B(rst_b), .SER_EN(en), .SER_CLK(sck), .SER_DATA(sda),
    .RECEIVE_ON(rx_on), .ANALOG_SUPPLY_LOW(sup_low), .AMP_ENABLE_REQ(amp_req),
    .STRENGTH_CLIP_DISABLE(clip), .LOW_SUPPLY_LOCKOUT_ARM(lock), .TX_RF_OUTPUT_TIMING(tm),
    .TX_POWER_PIN_STATE(pps), .CONTINUOUS_CARRIER_SELECT(cw), .ANALOG_OUT_FUNCTION(aof),
    .REFERENCE_FREQ_SELECT(ref_sel), .PUMP_POLARITY(pol), .CHANNEL_DIVIDE_RATIO_FIELD(channel_divide_ratio_field),
    .DIGITAL_TEST_SELECT(dts), .ANALOG_TEST_SELECT(ats), .AMPLIFIER_ENABLE_OUT(amp),
    .TX_RF_ENABLE(txrf), .POWER_PIN_OE(oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic put(input logic [13:0] d, input logic [1:0] s);
    i_host.send({d, s});
    repeat (8) @(negedge clk);
  endtask
  function automatic logic [15:0] cfg();
    return {6'h0, clip, lock, 1'b0, tm, pps, cw, 1'b0, aof, ref_sel, pol};
  endfunction
  task automatic t_cfg();
    for (int b = 0; b < 10; b++) begin
      if (b == 3 || b == 7) continue;
      put(14'h1 << b, rscr_pkg::SEL_CONFIG);
      chk("cfg", 16'h1 << b, cfg());
      chk("txrf", 16'(b != 6), 16'(txrf));
      chk("oe", 16'(b != 2 && b != 5), 16'(oe));
    end
  endtask
  task automatic t_regs();
    put(14'h0fff, rscr_pkg::SEL_CHANNEL);
    chk("chq", 16'h0fff, 16'(channel_divide_ratio_field));
    put(14'h0925, rscr_pkg::SEL_CHANNEL);
    chk("chq", 16'h0925, 16'(channel_divide_ratio_field));
    chk("cfg", 16'h0200, cfg());
    put(14'h002b, rscr_pkg::SEL_TEST);
    chk("test", 16'h002b, 16'({dts, ats}));
    put(14'h003f, 2'h3);
    chk("test", 16'h002b, 16'({dts, ats}));
    chk("chq", 16'h0925, 16'(channel_divide_ratio_field));
    chk("cfg", 16'h0200, cfg());
    i_host.noise();
    repeat (8) @(negedge clk);
    chk("chq", 16'h0925, 16'(channel_divide_ratio_field));
  endtask
  task automatic t_lock();
    put(14'h0100, rscr_pkg::SEL_CONFIG);
    amp_req = 1'b1;
    repeat (8) @(negedge clk);
    chk("amp", 16'h1, 16'(amp));
    sup_low = 1'b1;
    repeat (8) @(negedge clk);
    chk("amp", 16'h0, 16'(amp));
    sup_low = 1'b0;
    repeat (8) @(negedge clk);
    chk("amp", 16'h0, 16'(amp));
    rx_on = 1'b1;
    repeat (8) @(negedge clk);
    rx_on = 1'b0;
    chk("amp", 16'h1, 16'(amp));
    put(14'h0040, rscr_pkg::SEL_CONFIG);
    chk("txrf", 16'h1, 16'(txrf));
    amp_req = 1'b0;
    repeat (8) @(negedge clk);
    chk("txrf", 16'h0, 16'(txrf));
  endtask
  task automatic t_reset();
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk("cfg", 16'h0, cfg());
    chk("regs", 16'h0, {channel_divide_ratio_field, 4'h0} | 16'({dts, ats}));
    chk("amp", 16'h0, 16'(amp));
    chk("txrf", 16'h1, 16'(txrf));
    chk("oe", 16'h1, 16'(oe));
  endtask
  initial begin
    rx_on = 1'b0;
    sup_low = 1'b0;
    amp_req = 1'b0;
    t_reset();
    t_cfg();
    t_regs();
    t_lock();
    t_reset();
    tally_and_finish();
  end
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
